// *** rtl/cbt_regs.svh ***
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH

// Register word indices; byte address is four times the index
`define CBT_IDX_CTRL      6'h0F
`define CBT_IDX_STAT      6'h10

// Control register reset value, reserved bits read as one
`define CBT_CTRL_RESET    16'hE7FF
`define CBT_CTRL_RSVD     16'h07FF

// Status register field positions
`define CBT_ST_EMPTY      0
`define CBT_ST_FULL       1
`define CBT_ST_RANGE      2
`define CBT_ST_STATE_LO   4

// Buffer depths in bytes
`define CBT_DEPTH_512     13'h0200
`define CBT_DEPTH_1024    13'h0400
`define CBT_DEPTH_2048    13'h0800
`define CBT_DEPTH_4096    13'h1000

// Read clock edges before the first word comes out
`define CBT_RD_LAT        2'h2

// Last index of the single-port and two-port pattern sequences
`define CBT_PAT1_LAST     5'h13
`define CBT_PAT2_LAST     5'h09

// Synchroniser bit positions
`define CBT_SY_RCLK       0
`define CBT_SY_WEN        1
`define CBT_SY_REN        2
`define CBT_SY_BRST       3

`endif

// *** rtl/cbt_pkg.sv ***
package cbt_pkg;

  typedef struct packed {
    logic [1:0]  buffer_depth_select;
    logic        auto_stop_capture;
    logic        two_port_output_enable;
    logic        pattern_output_select;
    logic [10:0] rsvd;
  } cbt_ctrl_t;

  typedef enum logic [2:0] {
    CBT_EMPTY   = 3'b000,
    CBT_CAPTURE = 3'b001,
    CBT_FULL    = 3'b010,
    CBT_READ    = 3'b011,
    CBT_FROZEN  = 3'b100
  } cbt_state_t;

  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] secondary;
    logic       secondary_oe_n;
    logic       strobe;
  } cbt_out_t;

endpackage

// *** rtl/cbt_capture_buffer.sv ***
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "cbt_regs.svh"
// What this block does
// R1 - Pattern on primary port only, on both ports when two-port enable set.
// R2 - Pattern select replaces converter data on ports and range output.
// R3 - Pattern mode: range output high from pattern start until empty flag.
// R4 - Single port: 20-word pattern sequence, secondary port high-impedance.
// R5 - Two ports: pairs 01/02,03/04,FE/FD,FC/FB, ten pairs per sequence.
// R6 - Each pattern word comes with a strobe transition.
// R7 - Depth select 00..11 gives 512, 1024, 2048, 4096 bytes.
// R8 - Readout only after full depth written; never write and read together.
// R9 - Empty flag rises after last word read; no further reading.
// R10 - Capture starts only while empty flag high.
// R11 - Empty flag clears once synchronised write enable seen.
// R12 - Reading only while full; full clears on synchronised read enable.
// R13 - Buffer reset clears full, sets empty, aborts capture and readout.
// R14 - Samples stored at sample rate only while write enable asserted.
// R15 - Full buffer wraps and overwrites oldest; auto-stop halts at full.
// R16 - Data out on read clock rising edges while read enable asserted.
// R17 - Two-port bit zero: primary only; one: both ports carry data.
// R18 - Two-port: first word on secondary, next on primary, alternating.
// R19 - First data and strobe on third read clock edge after enable.
// R20 - Both enables: write wins, readout ignored, buffer frozen until reset.
// R21 - Capture-start sync output is write enable resynchronised.
// R22 - Range output set by out-of-range sample, clears when empty rises.
// R23 - After power-up: empty high, full low, idle.
module cbt_capture_buffer
  import cbt_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [7:0]  i_sample,
  input  wire logic        i_sample_over_range,
  input  wire logic        i_read_clock,
  input  wire logic        i_capture_write_enable,
  input  wire logic        i_readout_enable,
  input  wire logic        i_buffer_reset,
  output logic      [7:0]  o_primary_output_port,
  output logic      [7:0]  o_secondary_output_port,
  output logic             o_secondary_output_port_oe_n,
  output logic             o_output_data_strobe,
  output logic             o_buffer_empty_flag,
  output logic             o_buffer_full_flag,
  output logic             o_range_exceeded,
  output logic             o_capture_start_sync
);

  logic [7:0]  mem [0:4095];
  logic [3:0]  pins;
  logic [3:0]  sa_r;
  logic [3:0]  sb_r;
  logic [3:0]  sc_r;
  logic [3:0]  st_r;
  logic        rd_rise;
  logic        wen_s;
  logic        ren_s;
  logic        brst_s;
  cbt_ctrl_t   ctrl_r;
  logic [15:0] ctrl_wr;
  logic        ack_r;
  logic [31:0] rdata_r;
  cbt_state_t  state_r;
  logic        ef_r;
  logic        ff_r;
  logic        or_r;
  logic [11:0] wptr_r;
  logic [12:0] wcnt_r;
  logic [11:0] rptr_r;
  logic [12:0] rcnt_r;
  logic [1:0]  lat_r;
  logic [4:0]  pat_r;
  cbt_out_t    out_r;
  logic [12:0] depth;
  logic [11:0] mask;
  logic        two;
  logic        wr_en;
  logic        wr_last;
  logic        rd_start;
  logic        rd_step;
  logic        rd_last;
  logic [12:0] rcnt_nxt;

  function automatic logic [12:0] depth_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: depth_of = `CBT_DEPTH_512;
      2'h1: depth_of = `CBT_DEPTH_1024;
      2'h2: depth_of = `CBT_DEPTH_2048;
      2'h3: depth_of = `CBT_DEPTH_4096;
    endcase
  endfunction

  function automatic logic [7:0] pat_byte(input logic [2:0] idx);
    unique case (idx)
      3'h0: pat_byte = 8'h01;
      3'h1: pat_byte = 8'h02;
      3'h2: pat_byte = 8'h03;
      3'h3: pat_byte = 8'h04;
      3'h4: pat_byte = 8'hFE;
      3'h5: pat_byte = 8'hFD;
      3'h6: pat_byte = 8'hFC;
      3'h7: pat_byte = 8'hFB;
    endcase
  endfunction

  function automatic logic hits(input logic [7:0] addr,
                                input logic [5:0] idx);
    hits = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  assign pins[`CBT_SY_RCLK] = i_read_clock;
  assign pins[`CBT_SY_WEN]  = i_capture_write_enable;
  assign pins[`CBT_SY_REN]  = i_readout_enable;
  assign pins[`CBT_SY_BRST] = i_buffer_reset;

  // Three stages; a level counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          sa_r[g] <= 1'b0;
          sb_r[g] <= 1'b0;
          sc_r[g] <= 1'b0;
          st_r[g] <= 1'b0;
        end else begin
          sa_r[g] <= pins[g];
          sb_r[g] <= sa_r[g];
          sc_r[g] <= sb_r[g];
          if (sb_r[g] == sc_r[g]) begin
            st_r[g] <= sc_r[g];
          end
        end
      end
    end
  endgenerate

  assign rd_rise = sb_r[`CBT_SY_RCLK] & sc_r[`CBT_SY_RCLK]
                 & ~st_r[`CBT_SY_RCLK]; // see R16
  assign wen_s   = st_r[`CBT_SY_WEN];
  assign ren_s   = st_r[`CBT_SY_REN];
  assign brst_s  = st_r[`CBT_SY_BRST];

  assign depth = depth_of(ctrl_r.buffer_depth_select); // see R7
  assign mask  = 12'(depth - 13'h0001);
  assign two   = ctrl_r.two_port_output_enable;

  // Auto-stop blocks writes once full; otherwise pointer wraps
  assign wr_en   = (state_r == CBT_CAPTURE) & wen_s & ~(ren_s & ff_r)
                 & ~(ff_r & ctrl_r.auto_stop_capture); // see R14 see R15
  assign wr_last = wr_en & ~ff_r & (wcnt_r == depth - 13'h0001);

  // Write enable wins over read enable
  assign rd_start = (state_r == CBT_FULL) & ren_s & ~wen_s; // see R12
  assign rd_step  = (state_r == CBT_READ) & ~wen_s & ren_s & rd_rise
                  & (lat_r == `CBT_RD_LAT); // see R19 see R20
  assign rcnt_nxt = rcnt_r + (two ? 13'h0002 : 13'h0001);
  assign rd_last  = rd_step & (rcnt_nxt >= depth); // see R9

  // Bus slave: one wait cycle per access
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign o_avs_readdata    = rdata_r;

  always_comb begin
    ctrl_wr = ctrl_r;
    if (i_avs_byteenable[0]) begin
      ctrl_wr[7:0] = i_avs_writedata[7:0];
    end
    if (i_avs_byteenable[1]) begin
      ctrl_wr[15:8] = i_avs_writedata[15:8];
    end
    ctrl_wr = ctrl_wr | `CBT_CTRL_RSVD;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= (i_avs_read | i_avs_write) & ~ack_r;
      rdata_r <= 32'h00000000;
      if (hits(i_avs_address, `CBT_IDX_CTRL)) begin
        rdata_r <= {16'h0000, ctrl_r};
      end else if (hits(i_avs_address, `CBT_IDX_STAT)) begin
        rdata_r[`CBT_ST_EMPTY] <= ef_r;
        rdata_r[`CBT_ST_FULL]  <= ff_r;
        rdata_r[`CBT_ST_RANGE] <= or_r;
        rdata_r[`CBT_ST_STATE_LO +: 3] <= state_r;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= cbt_ctrl_t'(`CBT_CTRL_RESET);
    end else if (i_avs_write & ack_r
                 & hits(i_avs_address, `CBT_IDX_CTRL)) begin
      ctrl_r <= cbt_ctrl_t'(ctrl_wr);
    end
  end

  // Sequencing of capture and readout
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= CBT_EMPTY; // see R23
    end else if (brst_s) begin
      state_r <= CBT_EMPTY; // see R13
    end else begin
      unique case (state_r)
        CBT_EMPTY: begin
          if (wen_s) begin
            state_r <= CBT_CAPTURE; // see R10
          end
        end
        CBT_CAPTURE: begin
          if (ff_r & wen_s & ren_s) begin
            state_r <= CBT_FROZEN; // see R20
          end else if (ff_r & (~wen_s | ctrl_r.auto_stop_capture)) begin
            state_r <= CBT_FULL; // see R8
          end
        end
        CBT_FULL: begin
          if (wen_s & ren_s) begin
            state_r <= CBT_FROZEN; // see R20
          end else if (rd_start) begin
            state_r <= CBT_READ;
          end
        end
        CBT_READ: begin
          if (wen_s & ren_s) begin
            state_r <= CBT_FROZEN; // see R20
          end else if (rd_last) begin
            state_r <= CBT_EMPTY;
          end
        end
        CBT_FROZEN: begin
          state_r <= CBT_FROZEN;
        end
        default: begin
          state_r <= CBT_EMPTY;
        end
      endcase
    end
  end

  // Flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ef_r <= 1'b1; // see R23
      ff_r <= 1'b0;
    end else if (brst_s) begin
      ef_r <= 1'b1; // see R13
      ff_r <= 1'b0;
    end else begin
      if (state_r == CBT_EMPTY && wen_s) begin
        ef_r <= 1'b0; // see R11
      end
      if (rd_start) begin
        ff_r <= 1'b0; // see R12
      end
      if (rd_last) begin
        ef_r <= 1'b1; // see R9
      end
      if (wr_last) begin
        ff_r <= 1'b1; // see R8
      end
    end
  end

  // Sample store, no reset on the array
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem[wptr_r] <= i_sample; // see R14
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wptr_r <= 12'h000;
      wcnt_r <= 13'h0000;
    end else if (brst_s || (state_r == CBT_EMPTY)) begin
      wptr_r <= 12'h000;
      wcnt_r <= 13'h0000;
    end else if (wr_en) begin
      wptr_r <= (wptr_r + 12'h001) & mask; // see R15
      if (!ff_r) begin
        wcnt_r <= wcnt_r + 13'h0001;
      end
    end
  end

  // Readout; when full the write pointer marks the oldest word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rptr_r <= 12'h000;
      rcnt_r <= 13'h0000;
      lat_r  <= 2'h0;
      pat_r  <= 5'h00;
    end else if (brst_s) begin
      rcnt_r <= 13'h0000;
      lat_r  <= 2'h0;
      pat_r  <= 5'h00;
    end else if (rd_start) begin
      rptr_r <= wptr_r;
      rcnt_r <= 13'h0000;
      lat_r  <= 2'h0;
      pat_r  <= 5'h00;
    end else if (rd_step) begin
      rptr_r <= (rptr_r + (two ? 12'h002 : 12'h001)) & mask;
      rcnt_r <= rcnt_nxt;
      if (pat_r == (two ? `CBT_PAT2_LAST : `CBT_PAT1_LAST)) begin
        pat_r <= 5'h00; // see R4 see R5
      end else begin
        pat_r <= pat_r + 5'h01;
      end
    end else if ((state_r == CBT_READ) & ~wen_s & ren_s & rd_rise) begin
      lat_r <= lat_r + 2'h1; // see R19
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_r <= '{8'h00, 8'h00, 1'b1, 1'b0};
    end else begin
      out_r.secondary_oe_n <= ~two; // see R4 see R17
      if (rd_step) begin
        out_r.strobe <= ~out_r.strobe; // see R6
        if (ctrl_r.pattern_output_select) begin
          if (two) begin
            out_r.secondary <= pat_byte({pat_r[1:0], 1'b0}); // see R5
            out_r.primary   <= pat_byte({pat_r[1:0], 1'b1}); // see R1
          end else begin
            out_r.primary <= pat_byte(pat_r[2:0]); // see R2 see R4
          end
        end else if (two) begin
          out_r.secondary <= mem[rptr_r]; // see R18
          out_r.primary   <= mem[(rptr_r + 12'h001) & mask];
        end else begin
          out_r.primary <= mem[rptr_r]; // see R17
        end
      end
    end
  end

  // Range output; pattern mode ignores converter overrange
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      or_r <= 1'b0;
    end else if (brst_s) begin
      or_r <= 1'b0;
    end else begin
      if (rd_last) begin
        or_r <= 1'b0; // see R22 see R3
      end
      if (wr_en & i_sample_over_range
          & ~ctrl_r.pattern_output_select) begin
        or_r <= 1'b1; // see R22
      end
      if (rd_step & ~rd_last & ctrl_r.pattern_output_select) begin
        or_r <= 1'b1; // see R3
      end
    end
  end

  assign o_primary_output_port        = out_r.primary;
  assign o_secondary_output_port      = out_r.secondary;
  assign o_secondary_output_port_oe_n = out_r.secondary_oe_n;
  assign o_output_data_strobe         = out_r.strobe;
  assign o_buffer_empty_flag          = ef_r;
  assign o_buffer_full_flag           = ff_r;
  assign o_range_exceeded             = or_r;
  assign o_capture_start_sync         = wen_s; // see R21

endmodule

// *** bench/cbt_capture_buffer_checker.sv ***
`timescale 1ns/10ps
module cbt_capture_buffer_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_capture_write_enable,
  input wire logic i_readout_enable,
  input wire logic i_buffer_reset,
  input wire logic o_output_data_strobe,
  input wire logic o_buffer_empty_flag,
  input wire logic o_buffer_full_flag,
  input wire logic o_range_exceeded,
  input wire logic o_capture_start_sync
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence wen_rise_s;
    $rose(i_capture_write_enable) && o_buffer_empty_flag;
  endsequence
  sequence ren_rise_s;
    $rose(i_readout_enable) && o_buffer_full_flag
      && !i_capture_write_enable;
  endsequence
  pwr_idle_a: assert property ($fell(i_rst) |-> o_buffer_empty_flag
    && !o_buffer_full_flag && !o_range_exceeded) else $error("idle");
  flag_excl_a: assert property (!(o_buffer_empty_flag
    && o_buffer_full_flag)) else $error("flags both high");
  brst_flags_a: assert property (i_buffer_reset[*6] |->
    o_buffer_empty_flag && !o_buffer_full_flag) else $error("brst");
  empty_clr_a: assert property (wen_rise_s |->
    ##[2:6] !o_buffer_empty_flag) else $error("empty stuck");
  full_clr_a: assert property (ren_rise_s |->
    ##[2:6] !o_buffer_full_flag) else $error("full stuck");
  cap_start_a: assert property ($fell(o_buffer_empty_flag) |->
    i_capture_write_enable) else $error("capture start");
  sync_src_a: assert property ($rose(o_capture_start_sync) |->
    $past(i_capture_write_enable, 2)) else $error("start sync");
  no_reread_a: assert property ($changed(o_output_data_strobe) |->
    !$past(o_buffer_empty_flag)) else $error("read after empty");
  range_clr_a: assert property ($fell(o_range_exceeded) |->
    o_buffer_empty_flag) else $error("range cleared early");
endmodule
bind cbt_capture_buffer cbt_capture_buffer_checker u_chk (.*);

// *** bench/cbt_read_model.sv ***
`timescale 1ns/10ps
module cbt_read_model (
  input  wire logic       i_clk,
  input  wire logic       i_strobe,
  input  wire logic [7:0] i_primary,
  input  wire logic [7:0] i_secondary,
  output logic            o_read_clock
);
  logic [15:0] q[$];
  logic        strobe_r;
  // Free-running, odd offset keeps it unrelated to the sample clock
  initial begin
    o_read_clock = 1'b0;
    #137;
    forever #400 o_read_clock = ~o_read_clock;
  end
  initial strobe_r = 1'b0;
  // Word latched on each strobe transition
  always @(posedge i_clk) begin
    strobe_r <= i_strobe;
    if (i_strobe !== strobe_r)
      q.push_back({i_secondary, i_primary});
  end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic i_clk, i_rst, rd, wr, wen, ren, brst, ovr, rclk;
  logic wreq, oe_n, strobe, empty, full, rng, ssync;
  logic [7:0] addr, smp, pri, sec;
  logic [31:0] wdata, rdata, got;
  int n_fail, n_tests, cyc;
  logic [7:0] pat [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                          8'hFE, 8'hFD, 8'hFC, 8'hFB};

  cbt_capture_buffer DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_sample(smp), .i_sample_over_range(ovr), .i_read_clock(rclk),
    .i_capture_write_enable(wen), .i_readout_enable(ren),
    .i_buffer_reset(brst), .o_primary_output_port(pri),
    .o_secondary_output_port(sec), .o_secondary_output_port_oe_n(oe_n),
    .o_output_data_strobe(strobe), .o_buffer_empty_flag(empty),
    .o_buffer_full_flag(full), .o_range_exceeded(rng),
    .o_capture_start_sync(ssync));
  cbt_read_model u_rd (.i_clk(i_clk), .i_strobe(strobe),
    .i_primary(pri), .i_secondary(sec), .o_read_clock(rclk));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Counting samples make lost or repeated writes visible
  always @(posedge i_clk) smp <= smp + 8'h01;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge i_clk);
    end while (wreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wait_flag(input bit f, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge i_clk);
      if ((f ? full : empty) === v) break;
    end
    chk(f ? full : empty, v);
  endtask
  task automatic run_cap(input logic [15:0] c, input int n,
                         input bit two, input bit tp);
    logic [7:0] e0, e1;
    bus(1'b1, 8'h3C, {16'h0, c});
    bus(1'b0, 8'h3C, 32'h0);
    chk(got, {16'h0, c});
    u_rd.q.delete();
    wen <= 1'b1;
    wait_flag(1'b0, 1'b0, 20);
    ovr <= 1'b1;
    @(posedge i_clk);
    ovr <= 1'b0;
    repeat (n - 9) @(posedge i_clk);
    chk(full, 1'b0);
    wait_flag(1'b1, 1'b1, 30);
    wen <= 1'b0;
    repeat (6) @(posedge i_clk);
    ren <= 1'b1;
    wait_flag(1'b1, 1'b0, 20);
    for (int i = 0; i < 60 && u_rd.q.size() == 0; i++) @(posedge i_clk);
    chk(rng, 1'b1);
    chk(oe_n, !two);
    wait_flag(1'b0, 1'b1, n * 8 + 100);
    ren <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(rng, 1'b0);
    chk(u_rd.q.size(), two ? n / 2 : n);
    for (int k = 0; k < (two ? n / 2 : n); k++) begin
      if (two) begin
        e1 = tp ? pat[2 * ((k % 10) % 4)] : u_rd.q[0][15:8] + 8'(2 * k);
        e0 = tp ? pat[2 * ((k % 10) % 4) + 1] : e1 + 8'h01;
        chk(u_rd.q[k][15:8], e1);
      end else
        e0 = tp ? pat[(k % 20) % 8] : u_rd.q[0][7:0] + 8'(k);
      chk(u_rd.q[k][7:0], e0);
    end
  endtask
  task automatic abort_read();
    bus(1'b1, 8'h3C, 32'h27FF);
    wen <= 1'b1;
    wait_flag(1'b0, 1'b0, 20);
    wait_flag(1'b1, 1'b1, 600);
    wen <= 1'b0;
    repeat (6) @(posedge i_clk);
    ren <= 1'b1;
    repeat (100) @(posedge i_clk);
    brst <= 1'b1;
    repeat (6) @(posedge i_clk);
    brst <= 1'b0;
    ren <= 1'b0;
    chk({full, empty}, 2'b01);
    bus(1'b0, 8'h40, 32'h0);
    chk(got[1:0], 2'b01);
    wen <= 1'b1;
    wait_flag(1'b0, 1'b0, 20);
    wait_flag(1'b1, 1'b1, 600);
    u_rd.q.delete();
    ren <= 1'b1;
    repeat (60) @(posedge i_clk);
    bus(1'b0, 8'h40, 32'h0);
    chk(got[6:0], 7'h42);
    chk(u_rd.q.size(), 0);
    wen <= 1'b0;
    ren <= 1'b0;
  endtask

  initial begin
    i_rst = 1'b1;
    {rd, wr, wen, ren, brst, ovr} = 6'h00;
    addr = 8'h00;
    wdata = 32'h0;
    smp = 8'h00;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(1'b0, 8'h3C, 32'h0);
    chk(got, 32'h0000E7FF);
    bus(1'b0, 8'h40, 32'h0);
    chk(got, 32'h00000001);
    bus(1'b0, 8'h80, 32'h0);
    chk(got, 32'h0);
    run_cap(16'h47FF, 1024, 1'b0, 1'b0);
    run_cap(16'h97FF, 2048, 1'b1, 1'b0);
    run_cap(16'h37FF, 512, 1'b1, 1'b0);
    run_cap(16'h2FFF, 512, 1'b0, 1'b1);
    run_cap(16'h3FFF, 512, 1'b1, 1'b1);
    abort_read();
    final_report();
  end
endmodule
